/* core/spa_datapath.sv */
// Scratchpad, ALU, flags and page latch of the 8-bit processor datapath
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spa_datapath (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_awvalid,
  output var  logic        s_awready,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_wvalid,
  output var  logic        s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output var  logic        s_bvalid,
  input  wire logic        s_bready,
  output var  logic [1:0]  s_bresp,
  input  wire logic        s_arvalid,
  output var  logic        s_arready,
  input  wire logic [7:0]  s_araddr,
  output var  logic        s_rvalid,
  input  wire logic        s_rready,
  output var  logic [31:0] s_rdata,
  output var  logic [1:0]  s_rresp,
  input  wire logic        db_valid,
  input  wire logic        db_is_instr,
  input  wire logic [7:0]  db_data,
  output var  logic [7:0]  db_out,
  output var  logic        fetch_req,
  output var  logic        bus_req,
  output var  logic [1:0]  bus_kind,
  output var  logic [5:0]  module_addr
);
  logic [7:0]          spad_q [0:spa_pkg::SPAD_WORDS-1];
  logic                aw_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  logic [7:0]          acc_q, temp_q, instr_q, dout_q;
  spa_pkg::spa_ptr_t   ptr_q;
  logic [2:0]          page_q, cyc_q;
  logic                ovf_q, fetch_q, breq_q;
  logic [1:0]          bkind_q;
  logic [5:0]          mod_q;
  spa_pkg::spa_cmd_t   cmd_q;
  spa_pkg::spa_stat_t  stat_q;

  function automatic logic [2:0] ptr_step(input logic [2:0] v,
                                          input logic       up);
    return up ? v + 3'h1 : v - 3'h1;
  endfunction

  function automatic logic [8:0] bcd_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       c;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    c  = lo > spa_pkg::BCD_MAX;
    if (c) begin
      lo = lo + spa_pkg::BCD_ADJ;
    end
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c};
    if (hi > spa_pkg::BCD_MAX) begin
      hi = hi + spa_pkg::BCD_ADJ;
    end
    return {hi > spa_pkg::BCD_MAX + spa_pkg::BCD_ADJ || hi[4],
            hi[3:0], lo[3:0]};
  endfunction

  // Bus slave: both write channels taken together, one transfer at a time
  wire wr_fire = s_awvalid && s_wvalid && !aw_rdy_q && !bvalid_q;
  wire wr_take = aw_rdy_q && s_awvalid && s_wvalid;
  wire rd_fire = s_arvalid && !ar_rdy_q && !rvalid_q;
  wire rd_take = ar_rdy_q && s_arvalid;
  wire wr_map  = s_awaddr == spa_pkg::OFF_CMD || s_awaddr == spa_pkg::OFF_ACC
              || s_awaddr == spa_pkg::OFF_PTR;
  wire exec    = wr_take && s_awaddr == spa_pkg::OFF_CMD && &s_wstrb[2:0];
  wire acc_wr  = wr_take && s_awaddr == spa_pkg::OFF_ACC && s_wstrb[0];
  wire ptr_wr  = wr_take && s_awaddr == spa_pkg::OFF_PTR && s_wstrb[0];

  // Without a command the ALU passes the accumulator
  wire spa_pkg::spa_cmd_t cmd = exec ?
      spa_pkg::spa_cmd_t'(s_wdata[spa_pkg::CMD_W-1:0]) : '0;

  // Scratchpad address decode
  wire       indirect = !cmd.direct && cmd.acode >= spa_pkg::AC_IND;
  wire       sp_none  = !cmd.direct && cmd.acode == spa_pkg::AC_NONE;
  wire [5:0] sp_idx   = indirect ? ptr_q : {2'h0, cmd.acode};
  wire       sp_ok    = !sp_none && (!indirect || ptr_q.up < spa_pkg::PLANES);
  wire [7:0] sp_rd    = sp_ok ? spad_q[sp_idx] : spa_pkg::NULL_BYTE;
  wire       sp_use   = cmd.src == spa_pkg::SRC_SPAD
                     || cmd.dst == spa_pkg::DST_SPAD;
  wire       step     = exec && sp_use && indirect && !sp_none;
  wire       step_dec = step && cmd.acode == spa_pkg::AC_DEC;
  wire       step_inc = step && cmd.acode == spa_pkg::AC_INC;
  wire       sp_we    = exec && cmd.dst == spa_pkg::DST_SPAD && sp_ok;
  wire [7:0] reg_cur  = spad_q[spa_pkg::REG_CUR];
  wire [7:0] reg_alt  = spad_q[spa_pkg::REG_ALT];

  // ALU operand selection and operation
  wire [7:0] opa = acc_q;
  wire [7:0] opb = cmd.src == spa_pkg::SRC_SPAD ? sp_rd :
                   cmd.src == spa_pkg::SRC_TEMP ? temp_q : acc_q;
  wire [8:0] dsum = bcd_add(opa, opb);
  logic [7:0] res;
  logic       alu_c;
  always_comb begin
    alu_c = 1'b0;
    case (cmd.op)
      spa_pkg::OP_PASS: res = opb;
      spa_pkg::OP_AND:  res = opa & opb;
      spa_pkg::OP_OR:   res = opa | opb;
      spa_pkg::OP_XOR:  res = opa ^ opb;
      spa_pkg::OP_SHR:  res = {1'b0, opb[7:1]};
      spa_pkg::OP_SHL:  res = {opb[6:0], 1'b0};
      spa_pkg::OP_ADD:  res = opa + opb;
      spa_pkg::OP_DADD: begin
        res   = dsum[7:0];
        alu_c = dsum[8];
      end
      spa_pkg::OP_DEC:  res = opb - 8'h01;
      spa_pkg::OP_CMP: begin
        res   = opa - opb;
        alu_c = opa >= opb;
      end
      default:          res = opb;
    endcase
  end

  // Flags; null and msb follow the ALU outputs directly
  wire pfull_f = ptr_q.lo == spa_pkg::LOW_FULL;
  wire null_f  = res == spa_pkg::NULL_BYTE;
  wire msb_f   = res[7];
  wire shift_acc = exec && cmd.src == spa_pkg::SRC_ACC;
  wire ovf_d = (cmd.op == spa_pkg::OP_DADD || cmd.op == spa_pkg::OP_CMP)
               && exec ? alu_c :
               shift_acc && cmd.op == spa_pkg::OP_SHR ? 1'b0 :
               shift_acc && cmd.op == spa_pkg::OP_SHL ? 1'b1 : ovf_q;

  // Result routing
  wire [7:0] acc_d = acc_wr ? s_wdata[7:0] :
                     cmd.dst == spa_pkg::DST_ACC ? res : acc_q;
  // Data bus capture wins over a same-cycle result write
  wire [7:0] temp_d = db_valid ? db_data :
                      cmd.dst == spa_pkg::DST_TEMP ? res : temp_q;
  wire spa_pkg::spa_ptr_t res_ptr = spa_pkg::spa_ptr_t'(res[spa_pkg::PTR_W-1:0]);
  wire spa_pkg::spa_ptr_t wd_ptr =
      spa_pkg::spa_ptr_t'(s_wdata[spa_pkg::PTR_W-1:0]);
  wire [2:0] up_d = ptr_wr ? wd_ptr.up :
                    cmd.dst == spa_pkg::DST_PTR  ? res_ptr.up :
                    cmd.dst == spa_pkg::DST_PTRU ? res_ptr.lo : ptr_q.up;
  // Low field steps alone, wrapping in its three bits
  wire [2:0] lo_d = ptr_wr ? wd_ptr.lo :
                    cmd.dst == spa_pkg::DST_PTR  ? res_ptr.lo :
                    cmd.dst == spa_pkg::DST_PTRL ? res_ptr.lo :
                    step_dec ? ptr_step(ptr_q.lo, 1'b0) :
                    step_inc ? ptr_step(ptr_q.lo, 1'b1) : ptr_q.lo;
  wire [2:0] page_d = cmd.dst == spa_pkg::DST_PAGE ?
                      res[spa_pkg::PAGE_MSB:spa_pkg::PAGE_LSB] : page_q;

  // Outbound module address: fetch takes priority over other bus work
  wire       fetch_d = exec && cmd.last;
  wire       breq_d  = exec && !cmd.last && cmd.bus != spa_pkg::BUS_NONE;
  wire [5:0] mod_d   =
      fetch_d ? {page_q, 3'h0} :
      breq_d && cmd.bus == spa_pkg::BUS_PC_CUR ?
        {page_q, reg_cur[spa_pkg::TGT_MSB:0]} :
      breq_d ? {reg_alt[spa_pkg::PAGE_MSB:spa_pkg::PAGE_LSB],
                reg_alt[spa_pkg::TGT_MSB:0]} : mod_q;
  wire       ir_load = db_valid && db_is_instr;
  wire [2:0] cyc_d   = ir_load ? 3'h0 :
                       exec && cyc_q != spa_pkg::MAX_CYC ? cyc_q + 3'h1 : cyc_q;

  spa_pkg::spa_stat_t stat_d;
  always_comb begin
    stat_d              = '0;
    stat_d.pointer_full = pfull_f;
    stat_d.overflow     = ovf_q;
    stat_d.null_result  = null_f;
    stat_d.msb          = msb_f;
    stat_d.page         = page_q;
    stat_d.cycles       = cyc_q;
    stat_d.module_addr  = mod_q;
  end

  wire [31:0] rd_mux =
      s_araddr == spa_pkg::OFF_CMD   ? {15'h0, cmd_q} :
      s_araddr == spa_pkg::OFF_ACC   ? {24'h0, acc_q} :
      s_araddr == spa_pkg::OFF_PTR   ? {26'h0, ptr_q} :
      s_araddr == spa_pkg::OFF_STAT  ? stat_q :
      s_araddr == spa_pkg::OFF_TEMP  ? {24'h0, temp_q} :
      s_araddr == spa_pkg::OFF_INSTR ? {24'h0, instr_q} : 32'h0;
  wire rd_map = s_araddr == spa_pkg::OFF_CMD || s_araddr == spa_pkg::OFF_ACC
             || s_araddr == spa_pkg::OFF_PTR || s_araddr == spa_pkg::OFF_STAT
             || s_araddr == spa_pkg::OFF_TEMP || s_araddr == spa_pkg::OFF_INSTR;

  // Working registers carry no reset, as in the original RAM
  always_ff @(posedge aclk) begin
    if (sp_we) begin
      spad_q[sp_idx] <= res;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= spa_pkg::RESP_OK;
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= spa_pkg::RESP_OK;
      rdata_q  <= 32'h0;
    end else begin
      aw_rdy_q <= wr_fire;
      ar_rdy_q <= rd_fire;
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? spa_pkg::RESP_OK : spa_pkg::RESP_ERR;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_map ? spa_pkg::RESP_OK : spa_pkg::RESP_ERR;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q   <= 8'h00;
      temp_q  <= 8'h00;
      instr_q <= 8'h00;
      dout_q  <= 8'h00;
      ptr_q   <= '0;
      page_q  <= 3'h0;
      cyc_q   <= 3'h0;
      ovf_q   <= 1'b0;
      fetch_q <= 1'b0;
      breq_q  <= 1'b0;
      bkind_q <= 2'h0;
      mod_q   <= 6'h00;
      cmd_q   <= '0;
      stat_q  <= '0;
    end else begin
      acc_q   <= acc_d;
      temp_q  <= temp_d;
      dout_q  <= temp_q;
      ptr_q   <= {up_d, lo_d};
      page_q  <= page_d;
      cyc_q   <= cyc_d;
      ovf_q   <= ovf_d;
      fetch_q <= fetch_d;
      breq_q  <= breq_d;
      bkind_q <= breq_d ? cmd.bus : bkind_q;
      mod_q   <= mod_d;
      stat_q  <= stat_d;
      if (exec) begin
        cmd_q <= cmd;
      end
      if (ir_load) begin
        instr_q <= db_data;
      end
    end
  end

  assign s_awready   = aw_rdy_q;
  assign s_wready    = aw_rdy_q;
  assign s_bvalid    = bvalid_q;
  assign s_bresp     = bresp_q;
  assign s_arready   = ar_rdy_q;
  assign s_rvalid    = rvalid_q;
  assign s_rdata     = rdata_q;
  assign s_rresp     = rresp_q;
  assign db_out      = dout_q;
  assign fetch_req   = fetch_q;
  assign bus_req     = breq_q;
  assign bus_kind    = bkind_q;
  assign module_addr = mod_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire ptr_dst = cmd.dst == spa_pkg::DST_PTR || cmd.dst == spa_pkg::DST_PTRL;
  a_ptr_dec_step: assert property (step_dec && !ptr_dst |=>
      ptr_q.lo == $past(ptr_q.lo) - 3'h1 && $stable(ptr_q.up))
    else $error("low pointer field not decremented");
  a_ptr_inc_step: assert property (step_inc && !ptr_dst |=>
      ptr_q.lo == $past(ptr_q.lo) + 3'h1 && $stable(ptr_q.up))
    else $error("low pointer field not incremented");
  a_missing_plane: assert property (exec && indirect && ptr_q.up >= spa_pkg::PLANES
      && cmd.src == spa_pkg::SRC_SPAD && cmd.op == spa_pkg::OP_PASS
      && cmd.dst == spa_pkg::DST_ACC |=> acc_q == spa_pkg::NULL_BYTE)
    else $error("missing plane did not read zero");
  a_no_bad_write: assert property (exec && indirect
      && ptr_q.up >= spa_pkg::PLANES |-> !sp_we)
    else $error("write to missing plane");
  a_instr_hold: assert property (!ir_load |=> $stable(instr_q))
    else $error("instruction register changed without fetch");
  a_temp_pass: assert property (exec && cmd.op == spa_pkg::OP_PASS
      && cmd.src == spa_pkg::SRC_TEMP && cmd.dst == spa_pkg::DST_ACC
      |=> acc_q == $past(temp_q))
    else $error("pass-through altered data");
  a_bus_capture: assert property (db_valid |=> temp_q == $past(db_data))
    else $error("data bus value not captured");
  a_shift_flag: assert property (shift_acc && cmd.op == spa_pkg::OP_SHL
      |=> ovf_q ##1 (ovf_q || $past(exec)))
    else $error("left shift did not set overflow");
  a_ovf_clear: assert property (shift_acc && cmd.op == spa_pkg::OP_SHR |=> !ovf_q)
    else $error("right shift did not clear overflow");
  a_fetch_page: assert property (fetch_d |=> fetch_q && !breq_q
      && module_addr == {$past(page_q), 3'h0})
    else $error("fetch not on current page");
  a_cur_target: assert property (breq_d && cmd.bus == spa_pkg::BUS_PC_CUR
      |=> module_addr[spa_pkg::TGT_MSB:0] == $past(reg_cur[spa_pkg::TGT_MSB:0]))
    else $error("current page target bits wrong");
  a_idle_flags: assert property (!exec |=> stat_q.null_result
      == ($past(acc_q) == spa_pkg::NULL_BYTE) && stat_q.msb == $past(acc_q[7]))
    else $error("idle pass did not update flags");
  a_pfull_flag: assert property (
      stat_q.pointer_full == $past(ptr_q.lo == spa_pkg::LOW_FULL))
    else $error("pointer full flag wrong");
  a_null_flag: assert property (exec |=> stat_q.null_result
      == ($past(res) == spa_pkg::NULL_BYTE))
    else $error("null flag does not follow ALU output");
  a_msb_flag: assert property (exec |=> stat_q.msb == $past(res[7]))
    else $error("msb flag does not follow ALU output");
  a_page_load: assert property (exec && cmd.dst == spa_pkg::DST_PAGE
      |=> page_q == $past(res[spa_pkg::PAGE_MSB:spa_pkg::PAGE_LSB]))
    else $error("page latch not loaded");
  a_acc_route: assert property (exec && cmd.dst == spa_pkg::DST_ACC
      |=> acc_q == $past(res))
    else $error("result not routed to accumulator");
  a_cycle_cap: assert property (cyc_q <= spa_pkg::MAX_CYC)
    else $error("cycle count above four");
  a_alt_target: assert property (breq_d && cmd.bus != spa_pkg::BUS_PC_CUR
      |=> module_addr == $past(reg_alt[spa_pkg::PAGE_MSB:0]))
    else $error("alternate page address wrong");
  a_data_out: assert property (db_out == $past(temp_q))
    else $error("outgoing data not from temporary store");
  a_cmp_carry: assert property (exec && cmd.op == spa_pkg::OP_CMP
      |=> ovf_q == ($past(opa) >= $past(opb)))
    else $error("compare carry wrong");
endmodule // spa_datapath
`default_nettype wire

/* core/spa_pkg.sv */
// Shared constants and types for the scratchpad ALU datapath
package spa_pkg;
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_ACC   = 8'h04;
  localparam logic [7:0] OFF_PTR   = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_TEMP  = 8'h10;
  localparam logic [7:0] OFF_INSTR = 8'h14;
  localparam logic [1:0] RESP_OK   = 2'b00;
  localparam logic [1:0] RESP_ERR  = 2'b10;
  localparam int         SPAD_WORDS = 48;
  localparam int         PTR_W      = 6;
  localparam int         CMD_W      = 17;
  localparam logic [2:0] PLANES     = 3'h6;
  localparam logic [3:0] AC_IND     = 4'hc;
  localparam logic [3:0] AC_DEC     = 4'hd;
  localparam logic [3:0] AC_INC     = 4'he;
  localparam logic [3:0] AC_NONE    = 4'hf;
  localparam logic [5:0] REG_ALT    = 6'h0e;
  localparam logic [5:0] REG_CUR    = 6'h0f;
  localparam int         PAGE_LSB   = 3;
  localparam int         PAGE_MSB   = 5;
  localparam int         TGT_MSB    = 2;
  localparam logic [2:0] LOW_FULL   = 3'h7;
  localparam logic [2:0] MAX_CYC    = 3'h4;
  localparam logic [7:0] NULL_BYTE  = 8'h00;
  localparam logic [4:0] BCD_MAX    = 5'h09;
  localparam logic [4:0] BCD_ADJ    = 5'h06;

  typedef enum logic [3:0] {
    OP_PASS = 4'h0, OP_AND = 4'h1, OP_OR = 4'h2, OP_XOR = 4'h3,
    OP_SHR = 4'h4, OP_SHL = 4'h5, OP_ADD = 4'h6, OP_DADD = 4'h7,
    OP_DEC = 4'h8, OP_CMP = 4'h9
  } spa_op_t;
  typedef enum logic [1:0] {
    SRC_ACC = 2'h0, SRC_SPAD = 2'h1, SRC_TEMP = 2'h2
  } spa_src_t;
  typedef enum logic [2:0] {
    DST_NONE = 3'h0, DST_ACC = 3'h1, DST_TEMP = 3'h2, DST_PTR = 3'h3,
    DST_SPAD = 3'h4, DST_PAGE = 3'h5, DST_PTRU = 3'h6, DST_PTRL = 3'h7
  } spa_dst_t;
  typedef enum logic [1:0] {
    BUS_NONE = 2'h0, BUS_PC_CUR = 2'h1, BUS_PC_ALT = 2'h2, BUS_RD_ALT = 2'h3
  } spa_bus_t;

  typedef struct packed {
    spa_bus_t   bus;
    logic       direct;
    logic       last;
    logic [3:0] acode;
    spa_dst_t   dst;
    spa_src_t   src;
    spa_op_t    op;
  } spa_cmd_t;

  typedef struct packed {
    logic [2:0] up;
    logic [2:0] lo;
  } spa_ptr_t;

  typedef struct packed {
    logic [9:0] rsv_hi;
    logic [5:0] module_addr;
    logic [4:0] rsv_mid;
    logic [2:0] cycles;
    logic       rsv_lo;
    logic [2:0] page;
    logic       msb;
    logic       null_result;
    logic       overflow;
    logic       pointer_full;
  } spa_stat_t;
endpackage

/* verification/spa_mem_model.sv */
// Program memory and peripheral stand-in on the shared data bus
`timescale 1ns/1ps
`default_nettype none
module spa_mem_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] lat,
  input  wire logic       fetch_req,
  input  wire logic       bus_req,
  input  wire logic [1:0] bus_kind,
  input  wire logic [5:0] module_addr,
  output var  logic       db_valid,
  output var  logic       db_is_instr,
  output var  logic [7:0] db_data
);
  logic [3:0] wait_q;
  logic       busy_q;
  logic       instr_q;
  logic [7:0] val_q;
  logic       rd_req;
  assign rd_req = fetch_req || (bus_req && bus_kind == spa_pkg::BUS_RD_ALT);
  // Released bus never repeats the last byte
  always @(posedge aclk) begin
    db_valid <= 1'b0;
    db_is_instr <= 1'b0;
    db_data <= ~db_data;
    if (!aresetn) begin
      busy_q <= 1'b0;
      db_data <= 8'h5a;
    end else if (rd_req) begin
      busy_q <= 1'b1;
      wait_q <= lat;
      instr_q <= fetch_req;
      val_q <= {fetch_req ? 2'b01 : 2'b10, module_addr};
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      db_valid <= 1'b1;
      db_is_instr <= instr_q;
      db_data <= val_q;
    end
  end
endmodule // spa_mem_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the scratchpad ALU datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, db_valid, db_is_instr;
  logic        fetch_req, bus_req;
  logic [7:0]  awaddr, araddr, db_data, db_out;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, lat;
  logic [1:0]  bresp, rresp, bus_kind, b_kind;
  logic [5:0]  module_addr, f_addr, b_addr;
  int          failures, cmp_count, n_db;

  spa_datapath u_spa_datapath (.aclk(aclk), .aresetn(aresetn), .s_awvalid(awvalid),
    .s_awready(awready), .s_awaddr(awaddr), .s_wvalid(wvalid), .s_wready(wready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_bvalid(bvalid), .s_bready(bready),
    .s_bresp(bresp), .s_arvalid(arvalid), .s_arready(arready), .s_araddr(araddr),
    .s_rvalid(rvalid), .s_rready(rready), .s_rdata(rdata), .s_rresp(rresp),
    .db_valid(db_valid), .db_is_instr(db_is_instr), .db_data(db_data),
    .db_out(db_out), .fetch_req(fetch_req), .bus_req(bus_req),
    .bus_kind(bus_kind), .module_addr(module_addr));
  spa_mem_model u_spa_mem_model (.aclk(aclk), .aresetn(aresetn), .lat(lat),
    .fetch_req(fetch_req), .bus_req(bus_req), .bus_kind(bus_kind),
    .module_addr(module_addr), .db_valid(db_valid), .db_is_instr(db_is_instr),
    .db_data(db_data));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Counters move by NBA so tasks at the same edge see stable values
  always @(posedge aclk) begin
    if (fetch_req === 1'b1) f_addr <= module_addr;
    if (bus_req === 1'b1) b_addr <= module_addr;
    if (bus_req === 1'b1) b_kind <= bus_kind;
    if (db_valid === 1'b1) n_db <= n_db + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_pend;
    logic w_pend;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    // Each channel holds until its own ready
    while (aw_pend || w_pend) begin
      @(posedge aclk);
      if (aw_pend && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_pend && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(a, v, r);
    check(what, v, exp);
  endtask
  task automatic st_rd(output spa_pkg::spa_stat_t s);
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(spa_pkg::OFF_STAT, v, r);
    s = v;
  endtask
  // Flags field is {bus op, direct, last}
  task automatic cmd(input logic [3:0] op, input logic [1:0] s, input logic [2:0] d,
                     input logic [3:0] ac, input logic [3:0] fl);
    wr(spa_pkg::OFF_CMD, {15'h0, fl, ac, d, s, op});
  endtask
  task automatic mv(input logic [1:0] s, input logic [2:0] d, input logic [3:0] ac,
                    input logic [3:0] fl);
    cmd(spa_pkg::OP_PASS, s, d, ac, fl);
  endtask
  task automatic wait_db(input int n0);
    while (n_db == n0) @(posedge aclk);
    @(posedge aclk);
  endtask

  task automatic t_reset;
    logic [31:0] v;
    logic [1:0]  r;
    spa_pkg::spa_stat_t s;
    rchk("acc", spa_pkg::OFF_ACC, 32'h0);
    rchk("ptr", spa_pkg::OFF_PTR, 32'h0);
    rchk("temp", spa_pkg::OFF_TEMP, 32'h0);
    axi_rd(8'h40, v, r);
    check("rresp", 32'(r), 32'(spa_pkg::RESP_ERR));
    check("rdata", v, 32'h0);
    axi_wr(8'h40, 32'hff, r);
    check("bresp", 32'(r), 32'(spa_pkg::RESP_ERR));
    st_rd(s);
    check("null idle", 32'(s.null_result), 32'h1);
    $display("done reset");
  endtask

  task automatic t_alu;
    logic [3:0] ops [4];
    logic [7:0] ex [4];
    spa_pkg::spa_stat_t s;
    ops = '{spa_pkg::OP_AND, spa_pkg::OP_OR, spa_pkg::OP_XOR, spa_pkg::OP_PASS};
    ex = '{8'h00, 8'hff, 8'hff, 8'hc5};
    wr(spa_pkg::OFF_ACC, 32'hc5);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_TEMP, spa_pkg::AC_NONE, 4'h0);
    rchk("temp", spa_pkg::OFF_TEMP, 32'hc5);
    for (int i = 0; i < 4; i++) begin
      wr(spa_pkg::OFF_ACC, 32'h3a);
      cmd(ops[i], spa_pkg::SRC_TEMP, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
      rchk("logic op", spa_pkg::OFF_ACC, 32'(ex[i]));
      st_rd(s);
      check("null", 32'(s.null_result), 32'(ex[i] == 8'h00));
      check("msb", 32'(s.msb), 32'(ex[i][7]));
    end
    $display("done alu");
  endtask

  task automatic t_ovf;
    logic [31:0] v;
    spa_pkg::spa_stat_t s;
    logic [3:0] ops [4];
    logic [7:0] acc [4];
    logic [31:0] ex [4];
    ops = '{spa_pkg::OP_CMP, spa_pkg::OP_CMP, spa_pkg::OP_DADD, spa_pkg::OP_ADD};
    acc = '{8'h55, 8'h54, 8'h55, 8'h10};
    ex = '{32'h1, 32'h0, 32'h1, 32'h1};
    wr(spa_pkg::OFF_ACC, 32'h55);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_TEMP, spa_pkg::AC_NONE, 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(spa_pkg::OFF_ACC, 32'(acc[i]));
      cmd(ops[i], spa_pkg::SRC_TEMP, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
      st_rd(s);
      check("ovf", 32'(s.overflow), ex[i]);
    end
    rchk("bin add", spa_pkg::OFF_ACC, 32'h65);
    wr(spa_pkg::OFF_ACC, 32'h55);
    cmd(spa_pkg::OP_DADD, spa_pkg::SRC_TEMP, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
    rchk("dec add", spa_pkg::OFF_ACC, 32'h10);
    cmd(spa_pkg::OP_SHR, spa_pkg::SRC_ACC, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
    st_rd(s);
    check("ovf shr", 32'(s.overflow), 32'h0);
    wr(spa_pkg::OFF_ACC, 32'h01);
    cmd(spa_pkg::OP_SHL, spa_pkg::SRC_ACC, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
    st_rd(s);
    check("ovf shl", 32'(s.overflow), 32'h1);
    rchk("shl", spa_pkg::OFF_ACC, 32'h02);
    cmd(spa_pkg::OP_DEC, spa_pkg::SRC_TEMP, spa_pkg::DST_ACC, spa_pkg::AC_NONE, 4'h0);
    rchk("dec", spa_pkg::OFF_ACC, 32'h54);
    $display("done overflow");
  endtask

  task automatic t_spad;
    spa_pkg::spa_stat_t s;
    wr(spa_pkg::OFF_PTR, 32'h17);
    st_rd(s);
    check("ptr full", 32'(s.pointer_full), 32'h1);
    wr(spa_pkg::OFF_ACC, 32'h5a);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, spa_pkg::AC_INC, 4'h0);
    rchk("ptr inc", spa_pkg::OFF_PTR, 32'h10);
    wr(spa_pkg::OFF_ACC, 32'h33);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, spa_pkg::AC_IND, 4'h0);
    mv(spa_pkg::SRC_SPAD, spa_pkg::DST_ACC, spa_pkg::AC_DEC, 4'h0);
    rchk("ptr dec", spa_pkg::OFF_PTR, 32'h17);
    rchk("reg16", spa_pkg::OFF_ACC, 32'h33);
    mv(spa_pkg::SRC_SPAD, spa_pkg::DST_ACC, spa_pkg::AC_IND, 4'h0);
    rchk("reg23", spa_pkg::OFF_ACC, 32'h5a);
    wr(spa_pkg::OFF_ACC, 32'h77);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, 4'h3, 4'h0);
    for (int p = 6; p < 8; p++) begin
      wr(spa_pkg::OFF_PTR, {26'h0, 3'(p), 3'h3});
      wr(spa_pkg::OFF_ACC, 32'hee);
      mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, spa_pkg::AC_IND, 4'h0);
      mv(spa_pkg::SRC_SPAD, spa_pkg::DST_ACC, spa_pkg::AC_IND, 4'h0);
      rchk("plane read", spa_pkg::OFF_ACC, 32'h0);
    end
    mv(spa_pkg::SRC_SPAD, spa_pkg::DST_ACC, 4'h3, 4'h0);
    rchk("reg3 kept", spa_pkg::OFF_ACC, 32'h77);
    wr(spa_pkg::OFF_ACC, 32'h2c);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_PTR, spa_pkg::AC_NONE, 4'h0);
    wr(spa_pkg::OFF_ACC, 32'h03);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_PTRU, spa_pkg::AC_NONE, 4'h0);
    rchk("ptr alu", spa_pkg::OFF_PTR, 32'h1c);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_PTRL, spa_pkg::AC_NONE, 4'h0);
    rchk("ptr low", spa_pkg::OFF_PTR, 32'h1b);
    $display("done scratchpad");
  endtask

  task automatic t_page;
    spa_pkg::spa_stat_t s;
    int n0;
    wr(spa_pkg::OFF_ACC, 32'h2b);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, 4'hf, 4'h2);
    wr(spa_pkg::OFF_ACC, 32'h1e);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, 4'he, 4'h2);
    wr(spa_pkg::OFF_ACC, 32'h41);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_SPAD, 4'hc, 4'h2);
    wr(spa_pkg::OFF_PTR, 32'h0c);
    mv(spa_pkg::SRC_SPAD, spa_pkg::DST_ACC, spa_pkg::AC_IND, 4'h0);
    rchk("reg12", spa_pkg::OFF_ACC, 32'h41);
    mv(spa_pkg::SRC_SPAD, spa_pkg::DST_PAGE, 4'hf, 4'h2);
    st_rd(s);
    check("page", 32'(s.page), 32'h5);
    n0 = n_db;
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_NONE, spa_pkg::AC_NONE, 4'h1);
    wait_db(n0);
    check("fetch addr", 32'(f_addr), 32'h28);
    check("db_out", 32'(db_out), 32'h68);
    rchk("instr", spa_pkg::OFF_INSTR, 32'h68);
    repeat (5) mv(spa_pkg::SRC_ACC, spa_pkg::DST_NONE, spa_pkg::AC_NONE, 4'h0);
    st_rd(s);
    check("cycles", 32'(s.cycles), 32'(spa_pkg::MAX_CYC));
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_NONE, spa_pkg::AC_NONE, 4'h4);
    check("cur addr", {24'(b_kind), 2'h0, b_addr}, 32'h12b);
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_NONE, spa_pkg::AC_NONE, 4'h8);
    check("alt addr", {24'(b_kind), 2'h0, b_addr}, 32'h21e);
    lat <= 4'h5;
    n0 = n_db;
    mv(spa_pkg::SRC_ACC, spa_pkg::DST_NONE, spa_pkg::AC_NONE, 4'hc);
    wait_db(n0);
    check("rd addr", {24'(b_kind), 2'h0, b_addr}, 32'h31e);
    rchk("temp data", spa_pkg::OFF_TEMP, 32'h9e);
    rchk("instr held", spa_pkg::OFF_INSTR, 32'h68);
    $display("done page");
  endtask

  initial begin
    repeat (6000) @(posedge aclk);
    failures++;
    results;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, lat} = 52'h0;
    wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_alu;
    t_ovf;
    t_spad;
    t_page;
    results;
  end
endmodule // tb
`default_nettype wire
